// file: lcdc_pkg.sv
// Shared constants and types of the LCD command decoder, plus its voltage calculator.
package lcdc_pkg;

	// Opcode prefixes, compared against the upper bits of a command byte.
	localparam logic [2:0] FUNC_SET_PREFIX  = 3'h1;
	localparam logic [4:0] DISP_CTRL_PREFIX = 5'h01;
	localparam logic [3:0] PAGE_PREFIX      = 4'h4;
	localparam logic [6:0] RANGE_PREFIX     = 7'h02;
	localparam logic [4:0] ORDER_PREFIX     = 5'h01;
	localparam logic [4:0] BIAS_PREFIX      = 5'h02;

	// Field positions inside command bytes.
	localparam int DISP_D_BIT   = 2;
	localparam int DISP_E_BIT   = 0;
	localparam int DISP_ZERO_BIT = 1;
	localparam int ORDER_BIT    = 2;
	localparam int RANGE_BIT    = 0;
	localparam int FS_MX_BIT    = 4;
	localparam int FS_MY_BIT    = 3;
	localparam int FS_PD_BIT    = 2;
	localparam int FS_V_BIT     = 1;
	localparam int FS_H_BIT     = 0;

	// Address limits.
	localparam logic [3:0] PAGE_MAX = 4'h9;
	localparam logic [6:0] COL_MAX  = 7'h65;

	// Bias ratio at code zero; each code step lowers it by one.
	localparam logic [3:0] BIAS_BASE = 4'hB;

	// Drive voltage arithmetic in millivolts: offset plus code times step.
	localparam logic [13:0] VOFF_LOW_MV  = 14'hB7C;
	localparam logic [13:0] VOFF_HIGH_MV = 14'h1A5E;
	localparam logic [13:0] VSTEP_MV     = 14'h1E;

	// Reset values.
	localparam logic       RST_POWER_DOWN = 1'h1;
	localparam logic [3:0] RST_PAGE       = 4'h0;
	localparam logic [6:0] RST_COLUMN     = 7'h00;
	localparam logic [6:0] RST_VOP        = 7'h00;
	localparam logic [2:0] RST_BIAS_CODE  = 3'h0;

	// Display modes, decoded from the two mode bits.
	typedef enum logic [1:0] {
		DISP_BLANK,
		DISP_NORMAL,
		DISP_ALL_ON,
		DISP_INVERSE
	} lcdc_mode_type;

	// Command kinds that the decoder recognises.
	typedef enum logic [3:0] {
		CMD_NONE,
		CMD_FUNC,
		CMD_DISP,
		CMD_PAGE,
		CMD_COL,
		CMD_RANGE,
		CMD_ORDER,
		CMD_BIAS,
		CMD_VOP
	} lcdc_cmd_type;

	// One host transfer as delivered by the interface front end.
	typedef struct packed {
		logic       write;
		logic       read;
		logic       cmdDataSelect;
		logic [7:0] data;
	} lcdc_xfer_type;

	// Function-set fields.
	typedef struct packed {
		logic mirrorX;
		logic mirrorY;
		logic powerDown;
		logic vertical;
		logic extSet;
	} lcdc_func_type;

	// Display write toward the display RAM.
	typedef struct packed {
		logic       valid;
		logic [3:0] page;
		logic [6:0] column;
		logic [7:0] data;
	} lcdc_ram_type;

endpackage : lcdc_pkg

`timescale 1ns/1ns
// Turns the drive voltage code and range into millivolts and a pump enable.
module lcdc_vop_calc (
	// Programmed settings.
	input  wire logic [6:0]  vopCode,
	input  wire logic        voltageRangeSelect,
	// Results.
	output logic      [13:0] voltageMv,
	output logic             pumpOn
);
	import lcdc_pkg::*;

	// The product stays below 4 kV-equivalent millivolts, so 14 bits hold it.
	always_comb begin
		voltageMv = (voltageRangeSelect ? VOFF_HIGH_MV : VOFF_LOW_MV)
			+ 14'(VSTEP_MV * {7'h00, vopCode});
	end

	// An all-zero setting means no drive voltage is wanted at all.
	always_comb begin
		pumpOn = (vopCode != 7'h00) || voltageRangeSelect;
	end

endmodule // lcdc_vop_calc

// file: lcdc_command_decoder.sv
// Command decoder of the LCD controller: mode, address and drive settings.
`timescale 1ns/1ns

// What this block does
// - Display control: select low, 00001, bit1 zero
// - Mode bits map to blank/normal/all-on/inverse
// - Set page 0100 plus page 0..9
// - Set column: bit7 set, column 0..101
// - Extended 00001 sets row data order
// - Extended 00010 selects bias 11 down to 4
// - Extended bit7 loads seven-bit drive code
// - Range bit picks 2.94 or 6.75 offset
// - Pump off when code and range zero
// - Set bit chooses basic or extended commands
// - Data and function set always accepted
// - Data write advances column, wraps at end
module lcdc_command_decoder (
	// Clock and reset.
	input  wire logic                   clk,
	input  wire logic                   rst_n,
	// Host transfer from the interface front end.
	input  wire lcdc_pkg::lcdc_xfer_type hostIn,
	// Display settings.
	output lcdc_pkg::lcdc_mode_type     displayMode_reg,
	output lcdc_pkg::lcdc_func_type     funcSet_reg,
	output logic                        rowOrderLsb_reg,
	output logic [3:0]                  biasRatio_reg,
	// Addressing and RAM writes.
	output logic [3:0]                  page_reg,
	output logic [6:0]                  column_reg,
	output lcdc_pkg::lcdc_ram_type      ramWrite_reg,
	// Drive voltage.
	output logic [6:0]                  vopCode_reg,
	output logic                        voltageRangeSelect_reg,
	output logic [13:0]                 voltageMv_reg,
	output logic                        chargePumpOn_reg,
	// Status read answer.
	output logic [7:0]                  status_reg,
	output logic                        statusValid_reg
);
	import lcdc_pkg::*;

	// Classifies a command byte under the current instruction set.
	function automatic lcdc_cmd_type classify(input logic [7:0] b,
		input logic ext);
		classify = CMD_NONE;
		if (b[7:5] == FUNC_SET_PREFIX) begin
			classify = CMD_FUNC;
		end else if (!ext) begin
			if (b[7]) begin
				classify = CMD_COL;
			end else if (b[7:4] == PAGE_PREFIX) begin
				classify = CMD_PAGE;
			end else if (b[7:3] == DISP_CTRL_PREFIX && !b[DISP_ZERO_BIT]) begin
				classify = CMD_DISP;
			end else if (b[7:1] == RANGE_PREFIX) begin
				classify = CMD_RANGE;
			end
		end else begin
			if (b[7]) begin
				classify = CMD_VOP;
			end else if (b[7:3] == ORDER_PREFIX) begin
				classify = CMD_ORDER;
			end else if (b[7:3] == BIAS_PREFIX) begin
				classify = CMD_BIAS;
			end
		end
	endfunction

	// Maps the two mode bits onto a display mode.
	function automatic lcdc_mode_type decodeMode(input logic d,
		input logic e);
		case ({d, e})
			2'h0: decodeMode = DISP_BLANK;
			2'h2: decodeMode = DISP_NORMAL;
			2'h1: decodeMode = DISP_ALL_ON;
			default: decodeMode = DISP_INVERSE;
		endcase
	endfunction

	lcdc_cmd_type cmdKind;      // Kind of the byte now on the input.
	logic         cmdWr;        // Command write this cycle.
	logic         dataWr;       // Display data write this cycle.
	logic         statusRd;     // Status read this cycle.
	logic [13:0]  calcMv;       // Voltage from the calculator.
	logic         calcPump;     // Pump demand from the calculator.

	// Only writes with the select low are commands; reads change only the status answer.
	always_comb begin
		cmdWr    = hostIn.write && !hostIn.cmdDataSelect;
		dataWr   = hostIn.write && hostIn.cmdDataSelect;
		statusRd = hostIn.read && !hostIn.cmdDataSelect;
		cmdKind  = cmdWr ? classify(hostIn.data, funcSet_reg.extSet)
			: CMD_NONE;
	end

	// Function-set fields; the set bit steers decoding of every later command except function set itself.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			funcSet_reg <= '{1'h0, 1'h0, RST_POWER_DOWN, 1'h0, 1'h0};
		end else if (cmdKind == CMD_FUNC) begin
			funcSet_reg <= '{hostIn.data[FS_MX_BIT], hostIn.data[FS_MY_BIT],
				hostIn.data[FS_PD_BIT], hostIn.data[FS_V_BIT],
				hostIn.data[FS_H_BIT]};
		end
	end

	// Display mode from the display control command.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			displayMode_reg <= DISP_BLANK;
		end else if (cmdKind == CMD_DISP) begin
			displayMode_reg <= decodeMode(hostIn.data[DISP_D_BIT],
				hostIn.data[DISP_E_BIT]);
		end
	end

	// Page address; codes above the last page are dropped on purpose.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			page_reg <= RST_PAGE;
		end else if (cmdKind == CMD_PAGE && hostIn.data[3:0] <= PAGE_MAX) begin
			page_reg <= hostIn.data[3:0];
		end
	end

	// Column address: set by command, stepped by every display data write.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			column_reg <= RST_COLUMN;
		end else if (dataWr) begin
			column_reg <= (column_reg >= COL_MAX) ? 7'h00 : column_reg + 7'h01;
		end else if (cmdKind == CMD_COL && hostIn.data[6:0] <= COL_MAX) begin
			column_reg <= hostIn.data[6:0];
		end
	end

	// RAM write pulse carries the address in use before the step.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ramWrite_reg <= '0;
		end else begin
			ramWrite_reg <= '{dataWr, page_reg, column_reg, hostIn.data};
		end
	end

	// Row data order from the extended set.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rowOrderLsb_reg <= 1'h0;
		end else if (cmdKind == CMD_ORDER) begin
			rowOrderLsb_reg <= hostIn.data[ORDER_BIT];
		end
	end

	// Bias ratio: code zero is the highest ratio, counting down.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			biasRatio_reg <= BIAS_BASE - {1'h0, RST_BIAS_CODE};
		end else if (cmdKind == CMD_BIAS) begin
			biasRatio_reg <= BIAS_BASE - {1'h0, hostIn.data[2:0]};
		end
	end

	// Drive voltage code and range select.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			vopCode_reg            <= RST_VOP;
			voltageRangeSelect_reg <= 1'h0;
		end else if (cmdKind == CMD_VOP) begin
			vopCode_reg <= hostIn.data[6:0];
		end else if (cmdKind == CMD_RANGE) begin
			voltageRangeSelect_reg <= hostIn.data[RANGE_BIT];
		end
	end

	// The arithmetic lives apart so the analog model can reuse it.
	lcdc_vop_calc u_vop_calc (
		.vopCode            (vopCode_reg),
		.voltageRangeSelect (voltageRangeSelect_reg),
		.voltageMv          (calcMv),
		.pumpOn             (calcPump)
	);

	// Registered so the analog side never sees a combinational glitch.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			voltageMv_reg    <= VOFF_LOW_MV;
			chargePumpOn_reg <= 1'h0;
		end else begin
			voltageMv_reg    <= calcMv;
			chargePumpOn_reg <= calcPump;
		end
	end

	// Status answer to a read with the select low.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			status_reg      <= 8'h00;
			statusValid_reg <= 1'h0;
		end else begin
			statusValid_reg <= statusRd;
			if (statusRd) begin
				status_reg <= {funcSet_reg.powerDown, 2'h0,
					displayMode_reg == DISP_NORMAL
						|| displayMode_reg == DISP_INVERSE,
					displayMode_reg == DISP_ALL_ON
						|| displayMode_reg == DISP_INVERSE,
					funcSet_reg.mirrorX, funcSet_reg.mirrorY, rowOrderLsb_reg};
			end
		end
	end

	// Checks of the decoder's behaviour, one clock domain throughout.
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	property p_disp;
		cmdKind == CMD_DISP |=> displayMode_reg ==
			decodeMode($past(hostIn.data[2]), $past(hostIn.data[0]));
	endproperty
	a_disp: assert property (p_disp) else $error("Display mode wrong.");

	property p_page;
		cmdKind == CMD_PAGE |=> page_reg == ($past(hostIn.data[3:0]) > 4'h9
			? $past(page_reg) : $past(hostIn.data[3:0]));
	endproperty
	a_page: assert property (p_page) else $error("Page update wrong.");

	property p_col;
		cmdKind == CMD_COL && hostIn.data[6:0] > 7'h65 |=> $stable(column_reg);
	endproperty
	a_col: assert property (p_col) else $error("Bad column taken.");

	property p_order;
		cmdKind == CMD_ORDER |=> rowOrderLsb_reg == $past(hostIn.data[2]);
	endproperty
	a_order: assert property (p_order) else $error("Row order wrong.");

	property p_bias;
		cmdKind == CMD_BIAS |=> biasRatio_reg == 4'hB - $past(hostIn.data[2:0]);
	endproperty
	a_bias: assert property (p_bias) else $error("Bias ratio wrong.");

	property p_volt;
		cmdKind == CMD_VOP && !voltageRangeSelect_reg |=> ##1
			voltageMv_reg == 14'(2940 + 30 * $past(hostIn.data[6:0], 2));
	endproperty
	a_volt: assert property (p_volt) else $error("Voltage wrong.");

	property p_pump;
		##2 chargePumpOn_reg == ($past(vopCode_reg) != 7'h00
			|| $past(voltageRangeSelect_reg));
	endproperty
	a_pump: assert property (p_pump) else $error("Pump state wrong.");

	property p_basic_ignores_ext;
		cmdWr && !funcSet_reg.extSet && hostIn.data[7] |=> $stable(vopCode_reg);
	endproperty
	a_basic_ignores_ext: assert property (p_basic_ignores_ext)
		else $error("Extended command taken in basic set.");

	property p_wrap;
		dataWr && column_reg == 7'h65 |=> column_reg == 7'h00 ##0
			ramWrite_reg.valid && ramWrite_reg.column == 7'h65;
	endproperty
	a_wrap: assert property (p_wrap) else $error("Column wrap wrong.");

	property p_read_no_change;
		hostIn.read && !hostIn.write |=> $stable(funcSet_reg)
			&& $stable(displayMode_reg) && statusValid_reg == !$past(hostIn.cmdDataSelect);
	endproperty
	a_read_no_change: assert property (p_read_no_change)
		else $error("Read altered configuration.");

	c_inverse: cover property (cmdKind == CMD_DISP ##1
		displayMode_reg == DISP_INVERSE);
	c_wrap: cover property (dataWr && column_reg == COL_MAX);
	c_pump_off: cover property (chargePumpOn_reg ##1 !chargePumpOn_reg);
	c_ext_bias: cover property (cmdKind == CMD_BIAS);

endmodule // lcdc_command_decoder

// file: lcdc_host_model.sv
// Host processor model that issues command, data and status transfers.
`timescale 1ns/1ns
module lcdc_host_model (
	// Clock of the host transfer group.
	input  wire logic              clk,
	// Transfer toward the decoder.
	output lcdc_pkg::lcdc_xfer_type hostIn
);
	import lcdc_pkg::*;

	// Starts quiet so no strobe is seen during reset.
	initial begin
		hostIn = '{1'b0, 1'b0, 1'b0, 8'h00};
	end

	// One transfer, presented 1 ns after an edge and taken at the next edge.
	// The strobe stays up on return, so the caller must chain or go idle.
	task automatic xfer(input logic wr, input logic sel, input logic [7:0] d);
		hostIn = '{wr, ~wr, sel, d};
		@(posedge clk);
		#1;
	endtask

	// Drops both strobes; the bytes flip so stale values never look held.
	task automatic idle();
		hostIn = '{1'b0, 1'b0, ~hostIn.cmdDataSelect, ~hostIn.data};
		@(posedge clk);
		#1;
	endtask
endmodule // lcdc_host_model

// file: lcdc_command_decoder_tb.sv
// Self-checking testbench of the LCD command decoder.
`timescale 1ns/1ns
module lcdc_command_decoder_tb;
	import lcdc_pkg::*;

	logic          clk;         // System clock.
	logic          rst_n;       // Asynchronous reset, active low.
	lcdc_xfer_type hostIn;      // Transfer from the host model.
	lcdc_mode_type displayMode; // Decoded display mode.
	lcdc_func_type funcSet;     // Function-set fields.
	logic          rowOrderLsb; // Row data order.
	logic [3:0]    biasRatio;   // Bias ratio value.
	logic [3:0]    page;        // Current page.
	logic [6:0]    column;      // Current column.
	lcdc_ram_type  ramWrite;    // RAM write pulse.
	logic [6:0]    vopCode;     // Drive voltage code.
	logic          rangeSel;    // Drive voltage range.
	logic [13:0]   voltageMv;   // Drive level in millivolts.
	logic          pumpOn;      // Charge pump enable.
	logic [7:0]    status;      // Status byte.
	logic          statusValid; // Status pulse.
	int            fails;       // Mismatches seen.
	int            check_count; // Comparisons made.
	int            cycles;      // Cycles since start, for the hang guard.

	lcdc_host_model u_lcdc_host_model (
		.clk    (clk),
		.hostIn (hostIn)
	);

	lcdc_command_decoder u_lcdc_command_decoder (
		.clk                    (clk),
		.rst_n                  (rst_n),
		.hostIn                 (hostIn),
		.displayMode_reg        (displayMode),
		.funcSet_reg            (funcSet),
		.rowOrderLsb_reg        (rowOrderLsb),
		.biasRatio_reg          (biasRatio),
		.page_reg               (page),
		.column_reg             (column),
		.ramWrite_reg           (ramWrite),
		.vopCode_reg            (vopCode),
		.voltageRangeSelect_reg (rangeSel),
		.voltageMv_reg          (voltageMv),
		.chargePumpOn_reg       (pumpOn),
		.status_reg             (status),
		.statusValid_reg        (statusValid)
	);

	// Free-running 100 MHz clock.
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// Prints the counts and the verdict, then ends the run.
	task automatic stop_test();
		$display("checks %0d fails %0d", check_count, fails);
		if (fails == 0 && check_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// Four-state compare so an unknown never counts as a match.
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// Hang guard; the sequence needs well under a hundred cycles.
	always @(posedge clk) begin
		cycles++;
		if (cycles == 2000) begin
			fails++;
			$display("[ERR] %0t timeout", $time);
			stop_test();
		end
	end

	// Shorthands for a command write and a display data write.
	task automatic cmd(input logic [7:0] d);
		u_lcdc_host_model.xfer(1'b1, 1'b0, d);
	endtask
	task automatic dat(input logic [7:0] d);
		u_lcdc_host_model.xfer(1'b1, 1'b1, d);
	endtask

	// Main sequence; each check is made 1 ns after the edge that took it.
	initial begin
		fails = 0;
		check_count = 0;
		cycles = 0;
		rst_n = 1'b0;
		repeat (6) @(posedge clk);
		#1 rst_n = 1'b1;
		// Reset values.
		chk(16'(displayMode), 16'(DISP_BLANK));
		chk(16'(funcSet), 16'h0004);
		chk(16'(biasRatio), 16'h000B);
		chk(16'(voltageMv), 16'd2940);
		chk(16'(pumpOn), 16'h0000);
		// Every display mode, then a byte with bit 1 set that must be dropped.
		for (int i = 0; i < 4; i++) begin
			cmd({5'h01, i[1], 1'b0, i[0]});
			chk(16'(displayMode), {14'h0, i[0], i[1]});
		end
		cmd(8'h0A);
		chk(16'(displayMode), 16'(DISP_INVERSE));
		// Last legal page and column, then one past each.
		cmd(8'h49);
		chk(16'(page), 16'h0009);
		cmd(8'h4A);
		chk(16'(page), 16'h0009);
		cmd(8'hE5);
		chk(16'(column), 16'd101);
		cmd(8'hE6);
		chk(16'(column), 16'd101);
		// Data write at the last column wraps to zero.
		dat(8'hAA);
		chk(16'({ramWrite.valid, ramWrite.page, ramWrite.column}), 16'h0CE5);
		chk(16'(ramWrite.data), 16'h00AA);
		chk(16'(column), 16'h0000);
		// Extended set, chip active; data writes still advance.
		cmd(8'h21);
		chk(16'(funcSet), 16'h0001);
		dat(8'h55);
		chk(16'(column), 16'h0001);
		// Overlapping opcodes now mean row order; page setter is refused.
		cmd(8'h0C);
		chk(16'({displayMode, rowOrderLsb}), 16'h0007);
		cmd(8'h45);
		chk(16'(page), 16'h0009);
		// All bias codes.
		for (int c = 0; c < 8; c++) begin
			cmd(8'h10 | 8'(c));
			chk(16'(biasRatio), 16'(11 - c));
		end
		// Drive code five in the low range.
		cmd(8'h85);
		chk(16'(vopCode), 16'h0005);
		u_lcdc_host_model.idle();
		chk(16'(voltageMv), 16'(2940 + 5 * 30));
		chk(16'(pumpOn), 16'h0001);
		// Code zero in the low range stops the pump.
		cmd(8'h80);
		u_lcdc_host_model.idle();
		chk(16'({pumpOn, voltageMv}), 16'd2940);
		// Back to the basic set: high range keeps the pump on at code zero.
		cmd(8'h20);
		cmd(8'h05);
		u_lcdc_host_model.idle();
		chk(16'({pumpOn, voltageMv}), 16'h4000 | 16'd6750);
		cmd(8'h85);
		chk(16'({vopCode, 2'h0, column}), 16'h0005);
		// Status read, then a read with the select high that must be ignored.
		u_lcdc_host_model.xfer(1'b0, 1'b0, 8'h00);
		chk(16'({statusValid, status}), 16'h0119);
		u_lcdc_host_model.xfer(1'b0, 1'b1, 8'h00);
		chk(16'({statusValid, rangeSel}), 16'h0001);
		// Mirror and vertical fields of the function set.
		cmd(8'h3A);
		chk(16'(funcSet), 16'h001A);
		u_lcdc_host_model.idle();
		stop_test();
	end
endmodule // lcdc_command_decoder_tb
